/* dtc_pkg.sv */
/*
  Shared constants of the display timing core: register indices, field positions, reset values and the timing state.
  Assumes a word-wide plain register port; offsets below are word indices, byte address is four times the index.
*/
package dtc_pkg;
  // Register word indices
  localparam logic [3:0] DTC_IDX_MODE = 4'h0;
  localparam logic [3:0] DTC_IDX_CLK = 4'h1;
  localparam logic [3:0] DTC_IDX_BG = 4'h2;
  localparam logic [3:0] DTC_IDX_RES = 4'h3;
  localparam logic [3:0] DTC_IDX_FP = 4'h4;
  localparam logic [3:0] DTC_IDX_BLANK = 4'h5;
  localparam logic [3:0] DTC_IDX_BP = 4'h6;
  // Mode register bit positions
  localparam int DTC_B_MODULE_ON = 31;
  localparam int DTC_B_POINTER_ON = 30;
  localparam int DTC_B_VSYNC_INV = 28;
  localparam int DTC_B_HSYNC_INV = 27;
  localparam int DTC_B_DE_INV = 26;
  localparam int DTC_B_DIFFUSION = 24;
  localparam int DTC_B_VSYNC_SINGLE = 23;
  localparam int DTC_B_PCLK_INV = 22;
  localparam int DTC_B_GAMMA = 20;
  localparam int DTC_B_BLANK = 19;
  localparam int DTC_B_YUV = 9;
  localparam int DTC_B_FMT_UNDIV = 8;
  localparam int DTC_SEQ_LSB = 5;
  // Writable masks; unimplemented bits read zero
  localparam logic [31:0] DTC_MASK_MODE = 32'hDDD803E0;
  localparam logic [31:0] DTC_MASK_CLK = 32'h00003F3F;
  localparam logic [31:0] DTC_MASK_BG = 32'hFFFFFFFF;
  localparam logic [31:0] DTC_MASK_XY = 32'h07FF07FF;
  localparam logic [31:0] DTC_RESET_WORD = 32'h00000000;
  // Field positions of the clock register
  localparam int DTC_PREFETCH_LSB = 8;
  localparam logic [5:0] DTC_PREFETCH_MAX = 6'h20;
  localparam logic [5:0] DTC_DIV_MAX = 6'h1F;
  // Output sequencing codes
  localparam logic [2:0] DTC_SEQ_PARALLEL = 3'h0;
  localparam logic [2:0] DTC_SEQ_YUYV = 3'h6;
  localparam logic [2:0] DTC_SEQ_BT656 = 3'h7;
  // Field position of X halves
  localparam int DTC_X_LSB = 16;
  localparam logic [31:0] DTC_BG_ALL_SET = 32'hFFFFFFFF;
  // Phase of a line or a frame
  typedef enum logic [1:0] {DTC_ACTIVE, DTC_FRONT, DTC_SYNC, DTC_BACK} dtc_phase_t;
endpackage

/* dtc_display_timing_control.sv */
/*
  Display timing core: register file, pixel clock divider and the line/frame sequencer.
  Assumes the PLL clock is clk_sys_in and register accesses follow the one-cycle strobe protocol.
*/
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module dtc_display_timing_control
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Panel pins and background colour
  output logic pixel_clock_out,
  output logic horiz_sync_out,
  output logic vert_sync_out,
  output logic data_enable_out,
  output logic [31:0] background_rgba_out,
  output logic background_rgba_use_out,
  // Settings for the pixel pipeline
  output logic pointer_overlay_on_out,
  output logic error_diffusion_on_out,
  output logic gamma_ramp_on_out,
  output logic output_blank_force_out,
  output logic luma_chroma_output_sel_out,
  output logic format_clock_undivided_out,
  output logic [2:0] output_sequence_sel_out,
  output logic sequence_reserved_out,
  output logic [5:0] prefetch_line_count_out,
  output logic prefetch_start_out
);

  logic [31:0] mode_q, clk_q, bg_q, res_q, fp_q, blank_q, bp_q;
  logic [31:0] rdata_d, rdata_q;

  // Extract one 11-bit half of an X/Y register
  function automatic logic [10:0] dtc_half(input logic [31:0] w, input logic hi);
    dtc_half = hi ? w[DTC_X_LSB +: 11] : w[10:0];
  endfunction

  // Write decode
  wire wr_mode = reg_write_in && (reg_addr_in == DTC_IDX_MODE);
  wire wr_clk = reg_write_in && (reg_addr_in == DTC_IDX_CLK);
  wire wr_bg = reg_write_in && (reg_addr_in == DTC_IDX_BG);
  wire wr_res = reg_write_in && (reg_addr_in == DTC_IDX_RES);
  wire wr_fp = reg_write_in && (reg_addr_in == DTC_IDX_FP);
  wire wr_blank = reg_write_in && (reg_addr_in == DTC_IDX_BLANK);
  wire wr_bp = reg_write_in && (reg_addr_in == DTC_IDX_BP);

  // Register storage; masks drop writes to unimplemented bits
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mode_q <= DTC_RESET_WORD;
      clk_q <= DTC_RESET_WORD;
      bg_q <= DTC_RESET_WORD;
      res_q <= DTC_RESET_WORD;
      fp_q <= DTC_RESET_WORD;
      blank_q <= DTC_RESET_WORD;
      bp_q <= DTC_RESET_WORD;
    end else begin
      if (wr_mode) mode_q <= reg_wdata_in & DTC_MASK_MODE;
      if (wr_clk) clk_q <= reg_wdata_in & DTC_MASK_CLK;
      if (wr_bg) bg_q <= reg_wdata_in & DTC_MASK_BG;
      if (wr_res) res_q <= reg_wdata_in & DTC_MASK_XY;
      if (wr_fp) fp_q <= reg_wdata_in & DTC_MASK_XY;
      if (wr_blank) blank_q <= reg_wdata_in & DTC_MASK_XY;
      if (wr_bp) bp_q <= reg_wdata_in & DTC_MASK_XY;
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_read_in) begin
      case (reg_addr_in)
        DTC_IDX_MODE: rdata_d = mode_q;
        DTC_IDX_CLK: rdata_d = clk_q;
        DTC_IDX_BG: rdata_d = bg_q;
        DTC_IDX_RES: rdata_d = res_q;
        DTC_IDX_FP: rdata_d = fp_q;
        DTC_IDX_BLANK: rdata_d = blank_q;
        DTC_IDX_BP: rdata_d = bp_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) rdata_q <= 32'h00000000;
    else rdata_q <= rdata_d;
  end
  assign reg_rdata_out = rdata_q;

  // Mode decode
  wire module_on = mode_q[DTC_B_MODULE_ON];
  wire [5:0] pixel_clock_divisor = clk_q[5:0];
  wire [5:0] prefetch_raw = clk_q[DTC_PREFETCH_LSB +: 6];
  wire [5:0] prefetch_line_count = (prefetch_raw > DTC_PREFETCH_MAX) ? DTC_PREFETCH_MAX : prefetch_raw;
  // Reserved and zero divisors are clamped so the divider never stalls
  wire [5:0] div_eff = (pixel_clock_divisor > DTC_DIV_MAX) ? DTC_DIV_MAX :
                       (pixel_clock_divisor == 6'h00) ? 6'h01 : pixel_clock_divisor;
  // High phase: half rounded up, so odd divisors stay high one clock longer than low
  wire [5:0] div_high = (div_eff + 6'h01) >> 1;
  wire [2:0] seq = mode_q[DTC_SEQ_LSB +: 3];
  wire seq_reserved = (seq != DTC_SEQ_PARALLEL) && (seq != DTC_SEQ_YUYV) && (seq != DTC_SEQ_BT656);

  // Pixel clock divider from the PLL clock
  logic [5:0] div_cnt_q;
  logic pclk_q;
  wire div_wrap = (div_cnt_q >= div_eff - 6'h01);
  wire pix_tick = module_on && div_wrap;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !module_on) begin
      div_cnt_q <= 6'h00;
      pclk_q <= 1'b0;
    end else begin
      div_cnt_q <= div_wrap ? 6'h00 : div_cnt_q + 6'h01;
      pclk_q <= (div_wrap ? 6'h00 : div_cnt_q + 6'h01) < div_high;
    end
  end

  // Horizontal and vertical sequencers: horizontal steps once per pixel tick, vertical once per line end
  dtc_phase_t hph_q, vph_q;
  logic [10:0] hcnt_q, vcnt_q;
  logic [10:0] hlen, vlen;
  always_comb begin
    case (hph_q)
      DTC_ACTIVE: hlen = dtc_half(res_q, 1'b1);
      DTC_FRONT: hlen = dtc_half(fp_q, 1'b1);
      DTC_SYNC: hlen = dtc_half(blank_q, 1'b1);
      DTC_BACK: hlen = dtc_half(bp_q, 1'b1);
      default: hlen = 11'h000;
    endcase
    case (vph_q)
      DTC_ACTIVE: vlen = dtc_half(res_q, 1'b0);
      DTC_FRONT: vlen = dtc_half(fp_q, 1'b0);
      DTC_SYNC: vlen = dtc_half(blank_q, 1'b0);
      DTC_BACK: vlen = dtc_half(bp_q, 1'b0);
      default: vlen = 11'h000;
    endcase
  end
  // A zero-length phase is left at once rather than wrapping 2048 ticks
  wire h_done = (hlen == 11'h000) || (hcnt_q >= hlen - 11'h001);
  wire v_done = (vlen == 11'h000) || (vcnt_q >= vlen - 11'h001);
  wire line_end = pix_tick && h_done && (hph_q == DTC_BACK);
  wire frame_end = line_end && v_done && (vph_q == DTC_BACK);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !module_on) begin
      hph_q <= DTC_ACTIVE;
      vph_q <= DTC_ACTIVE;
      hcnt_q <= 11'h000;
      vcnt_q <= 11'h000;
    end else if (pix_tick) begin
      if (h_done) begin
        hcnt_q <= 11'h000;
        case (hph_q)
          DTC_ACTIVE: hph_q <= DTC_FRONT;
          DTC_FRONT: hph_q <= DTC_SYNC;
          DTC_SYNC: hph_q <= DTC_BACK;
          DTC_BACK: hph_q <= DTC_ACTIVE;
          default: hph_q <= DTC_ACTIVE;
        endcase
      end else begin
        hcnt_q <= hcnt_q + 11'h001;
      end
      if (line_end) begin
        if (v_done) begin
          vcnt_q <= 11'h000;
          case (vph_q)
            DTC_ACTIVE: vph_q <= DTC_FRONT;
            DTC_FRONT: vph_q <= DTC_SYNC;
            DTC_SYNC: vph_q <= DTC_BACK;
            DTC_BACK: vph_q <= DTC_ACTIVE;
            default: vph_q <= DTC_ACTIVE;
          endcase
        end else begin
          vcnt_q <= vcnt_q + 11'h001;
        end
      end
    end
  end

  // Internal active-high senses
  wire hs_int = module_on && (hph_q == DTC_SYNC);
  // Single-cycle mode: one pixel at line start while in vertical sync
  wire vs_line = module_on && (vph_q == DTC_SYNC);
  wire vs_int = mode_q[DTC_B_VSYNC_SINGLE] ?
                (vs_line && (hph_q == DTC_ACTIVE) && (hcnt_q == 11'h000)) : vs_line;
  wire de_int = module_on && (hph_q == DTC_ACTIVE) && (vph_q == DTC_ACTIVE)
                && !mode_q[DTC_B_BLANK];

  // Pin stage; polarity applied only here
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pixel_clock_out <= 1'b0;
      horiz_sync_out <= 1'b0;
      vert_sync_out <= 1'b0;
      data_enable_out <= 1'b0;
      prefetch_start_out <= 1'b0;
    end else begin
      pixel_clock_out <= pclk_q ^ mode_q[DTC_B_PCLK_INV];
      horiz_sync_out <= hs_int ^ mode_q[DTC_B_HSYNC_INV];
      vert_sync_out <= vs_int ^ mode_q[DTC_B_VSYNC_INV];
      data_enable_out <= de_int ^ mode_q[DTC_B_DE_INV];
      prefetch_start_out <= frame_end;
    end
  end

  // Settings handed to the pixel pipeline, registered
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      background_rgba_out <= 32'h00000000;
      background_rgba_use_out <= 1'b0;
      pointer_overlay_on_out <= 1'b0;
      error_diffusion_on_out <= 1'b0;
      gamma_ramp_on_out <= 1'b0;
      output_blank_force_out <= 1'b0;
      luma_chroma_output_sel_out <= 1'b0;
      format_clock_undivided_out <= 1'b0;
      output_sequence_sel_out <= DTC_SEQ_PARALLEL;
      sequence_reserved_out <= 1'b0;
      prefetch_line_count_out <= 6'h00;
    end else begin
      background_rgba_out <= bg_q;
      background_rgba_use_out <= (bg_q == DTC_BG_ALL_SET);
      pointer_overlay_on_out <= module_on && mode_q[DTC_B_POINTER_ON];
      error_diffusion_on_out <= mode_q[DTC_B_DIFFUSION];
      gamma_ramp_on_out <= mode_q[DTC_B_GAMMA];
      output_blank_force_out <= mode_q[DTC_B_BLANK];
      luma_chroma_output_sel_out <= mode_q[DTC_B_YUV];
      format_clock_undivided_out <= mode_q[DTC_B_FMT_UNDIV];
      output_sequence_sel_out <= seq;
      sequence_reserved_out <= seq_reserved;
      prefetch_line_count_out <= prefetch_line_count;
    end
  end

endmodule // dtc_display_timing_control

/* dtc_sva.sv */
/*
  Checker of the display timing core: register shadow and port relations.
  Assumes a bind onto the top module, whose port names it shares.
*/
`timescale 1ns/100ps
module dtc_sva
  import dtc_pkg::*;
(
  // Clock, reset, register port and background colour
  input wire logic clk_sys_in, rst_in, reg_write_in, reg_read_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in, reg_rdata_out, background_rgba_out,
  // Pins and settings
  input wire logic pixel_clock_out, horiz_sync_out, vert_sync_out, data_enable_out, background_rgba_use_out,
  input wire logic pointer_overlay_on_out, error_diffusion_on_out, gamma_ramp_on_out, output_blank_force_out,
  input wire logic luma_chroma_output_sel_out, format_clock_undivided_out, sequence_reserved_out, prefetch_start_out,
  input wire logic [2:0] output_sequence_sel_out,
  input wire logic [5:0] prefetch_line_count_out
);
  logic [31:0] sh [7];
  logic [31:0] rexp_q;
  wire [31:0] msk = reg_addr_in == 4'h0 ? DTC_MASK_MODE : reg_addr_in == 4'h1 ? DTC_MASK_CLK :
    reg_addr_in == 4'h2 ? DTC_MASK_BG : DTC_MASK_XY;
  wire [31:0] m = sh[0];
  wire [31:0] c = sh[1];
  wire [31:0] bg = sh[2];
  // Shadow of the register file; unmapped writes fall away
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < 7; i++) sh[i] <= '0;
      rexp_q <= '0;
    end else begin
      if (reg_write_in && reg_addr_in < 4'h7) sh[reg_addr_in[2:0]] <= reg_wdata_in & msk;
      rexp_q <= (reg_read_in && reg_addr_in < 4'h7) ? sh[reg_addr_in[2:0]] : 32'h0;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Three steady cycles so the idle level has reached the pins
  sequence s_off; (!m[31] && $stable(m))[*3]; endsequence
  sequence s_blank; (m[19] && $stable(m))[*3]; endsequence
  property p_off; s_off |-> {data_enable_out, vert_sync_out, horiz_sync_out, pixel_clock_out} == {m[26], m[28], m[27], m[22]}; endproperty
  a_off: assert property (p_off) else $error("idle pins wrong");
  property p_blank; s_blank |-> data_enable_out == m[26]; endproperty
  a_blank: assert property (p_blank) else $error("data enable during blank");
  property p_rd_data; $past(reg_read_in) |-> reg_rdata_out == rexp_q; endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  property p_rd_idle; !$past(reg_read_in) |-> reg_rdata_out == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_overlay; pointer_overlay_on_out == ($past(m[31]) && $past(m[30])); endproperty
  a_overlay: assert property (p_overlay) else $error("overlay wrong");
  property p_flags; {error_diffusion_on_out, gamma_ramp_on_out, output_blank_force_out, luma_chroma_output_sel_out,
    format_clock_undivided_out} == $past({m[24], m[20], m[19], m[9], m[8]}); endproperty
  a_flags: assert property (p_flags) else $error("mode flags wrong");
  property p_seq; output_sequence_sel_out == $past(m[7:5])
    && sequence_reserved_out == !($past(m[7:5]) inside {3'h0, 3'h6, 3'h7}); endproperty
  a_seq: assert property (p_seq) else $error("sequencing wrong");
  property p_pref; prefetch_line_count_out == ($past(c[13:8]) > 6'h20 ? 6'h20 : $past(c[13:8])); endproperty
  a_pref: assert property (p_pref) else $error("prefetch count wrong");
  property p_bg; background_rgba_out == $past(bg) && background_rgba_use_out == ($past(bg) == 32'hFFFFFFFF); endproperty
  a_bg: assert property (p_bg) else $error("background wrong");
  property p_pstart; prefetch_start_out |=> !prefetch_start_out; endproperty
  a_pstart: assert property (p_pstart) else $error("prefetch start too long");
endmodule // dtc_sva
bind dtc_display_timing_control dtc_sva i_dtc_sva (.*);

/* dtc_panel_model.sv */
/*
  Panel model: measures run lengths of the panel pins in system clocks.
  Assumes the bench tells it the programmed pin polarities.
*/
`timescale 1ns/100ps
module dtc_panel_model (
  // Pins: pixel clock, hsync, vsync, data enable
  input wire logic clk_in,
  input wire logic [3:0] sig_in,
  input wire logic [3:0] inv_in,
  // Last high run of each, and pixel clock period
  output int run_out [4],
  output int per_out
);
  logic [3:0] prev = 4'h0;
  int cnt [4] = '{0, 0, 0, 0};
  int pc = 0;
  wire [3:0] lvl = sig_in ^ inv_in;
  // Runs end on a fall; the period restarts on each rise
  always @(posedge clk_in) begin
    prev <= lvl;
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= lvl[i] ? cnt[i] + 1 : 0;
      if (prev[i] && !lvl[i]) run_out[i] <= cnt[i];
    end
    pc <= (lvl[0] && !prev[0]) ? 1 : pc + 1;
    if (lvl[0] && !prev[0]) per_out <= pc;
  end
endmodule // dtc_panel_model

/* tb_display_timing_control.sv */
/*
  Bench of the display timing core: register traffic, settings and pin timing.
  Assumes the checker is bound in and the panel model watches the pins.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_display_timing_control;
  import dtc_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, reg_write_in = 0, reg_read_in = 0;
  logic [3:0] reg_addr_in = 0, inv = 0;
  logic [31:0] reg_wdata_in = 0, reg_rdata_out, background_rgba_out, d;
  logic pixel_clock_out, horiz_sync_out, vert_sync_out, data_enable_out, background_rgba_use_out, seen;
  logic pointer_overlay_on_out, error_diffusion_on_out, gamma_ramp_on_out, output_blank_force_out;
  logic luma_chroma_output_sel_out, format_clock_undivided_out, sequence_reserved_out, prefetch_start_out;
  logic [2:0] output_sequence_sel_out;
  logic [5:0] prefetch_line_count_out;
  logic [31:0] mirror [16];
  int error_cnt = 0, comparisons = 0, run [4], per, v, dv;
  int pv [4] = '{0, 32, 33, 63};
  int divs [3] = '{2, 3, 40};
  dtc_display_timing_control i_dtc_display_timing_control (.*);
  dtc_panel_model i_dtc_panel_model (.clk_in(clk_sys_in), .inv_in(inv), .run_out(run), .per_out(per),
    .sig_in({data_enable_out, vert_sync_out, horiz_sync_out, pixel_clock_out}));
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] mask_of(int a);
    return a == 0 ? DTC_MASK_MODE : a == 1 ? DTC_MASK_CLK : a == 2 ? DTC_MASK_BG : a < 7 ? DTC_MASK_XY : 32'h0;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk_sys_in);
    reg_addr_in <= a; reg_wdata_in <= w; reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
    mirror[a] = w & mask_of(a);
  endtask
  task automatic chk_rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    reg_addr_in <= a; reg_read_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    #1 `CHK(reg_rdata_out, mirror[a])
  endtask
  // Settings follow the mode word one cycle after it lands
  task automatic chk_mode();
    logic [31:0] m;
    m = mirror[0];
    repeat (2) @(posedge clk_sys_in);
    #1 `CHK({pointer_overlay_on_out, error_diffusion_on_out, gamma_ramp_on_out, output_blank_force_out,
      luma_chroma_output_sel_out, format_clock_undivided_out, output_sequence_sel_out, sequence_reserved_out},
      {m[31] & m[30], m[24], m[20], m[19], m[9], m[8], m[7:5], !(m[7:5] inside {3'h0, 3'h6, 3'h7})})
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(4 * 60000);
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(32'h9ea6de17));
    for (int i = 0; i < 16; i++) mirror[i] = 0;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 16; i++) chk_rd(4'(i));
    // Random words at random places, unmapped ones included
    for (int n = 0; n < 40; n++) begin
      v = $urandom % 16;
      wr(4'(v), $urandom);
      chk_rd(4'(v));
      if (v == 0) chk_mode();
    end
    for (int s = 0; s < 8; s++) begin
      wr(4'h0, ($urandom & ~32'h000000E0) | 32'(s << 5));
      chk_mode();
    end
    // Prefetch depth saturates at 32 lines
    foreach (pv[i]) begin
      wr(4'h1, 32'(pv[i] << 8));
      repeat (2) @(posedge clk_sys_in);
      #1 `CHK(prefetch_line_count_out, 6'(pv[i] > 32 ? 32 : pv[i]))
    end
    wr(4'h2, 32'hFFFFFFFF);
    repeat (2) @(posedge clk_sys_in);
    #1 `CHK({background_rgba_use_out, background_rgba_out}, {1'b1, 32'hFFFFFFFF})
    wr(4'h2, 32'hFFFFFFFE);
    repeat (2) @(posedge clk_sys_in);
    #1 `CHK(background_rgba_use_out, 1'b0)
    // Small panel: 3x2 active, porches 1, hsync 2 ticks, vsync 1 line
    wr(4'h3, 32'h00030002);
    wr(4'h4, 32'h00010001);
    wr(4'h5, 32'h00020001);
    wr(4'h6, 32'h00010001);
    foreach (divs[k]) for (int p = 0; p < 2; p++) begin
      dv = divs[k] > 31 ? 31 : divs[k];
      inv = p ? 4'hF : 4'h0;
      wr(4'h1, 32'(divs[k]));
      wr(4'h0, p ? 32'h9C400000 : 32'h80000000);
      repeat (2500) @(posedge clk_sys_in);
      `CHK(per, dv)
      `CHK(run[0], (dv + 1) / 2)
      `CHK(run[1], 2 * dv)
      `CHK(run[2], 7 * dv)
      `CHK(run[3], 3 * dv)
    end
    // Single-cycle vsync: one tick per sync line; one prefetch pulse per frame of 35 ticks
    inv = 4'h0;
    wr(4'h0, 32'h80800000);
    repeat (2500) @(posedge clk_sys_in);
    `CHK(run[2], dv)
    v = 0;
    repeat (35 * dv) begin
      @(posedge clk_sys_in);
      #1 v += int'(prefetch_start_out);
    end
    `CHK(v, 1)
    // Forced blank keeps data enable away; skip the cycle still launched by the old mode
    wr(4'h0, 32'h80080000);
    seen = 0;
    repeat (2) @(posedge clk_sys_in);
    repeat (200) begin
      @(posedge clk_sys_in);
      #1 seen |= data_enable_out;
    end
    `CHK(seen, 1'b0)
    wr(4'h0, 32'h1C000000);
    repeat (20) @(posedge clk_sys_in);
    `CHK({data_enable_out, vert_sync_out, horiz_sync_out, pixel_clock_out}, 4'hE)
    close_out();
  end
endmodule // tb_display_timing_control
